// >>> design/epvu_exception_unit.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Reset exception starts on init pin rising edge or on watchdog overflow.
// - While init pin is low the CPU is held and nothing is processed.
// - Priority order: reset, trace, direct transition, interrupt, trap.
// - Trace exception at each boundary when the trace flag is one.
// - Trace only acts in interrupt control mode 2.
// - No trace after a return-from-handler instruction completes.
// - Sleep causing a direct transition starts the direct transition exception.
// - Pending interrupt request is taken at an instruction or handling boundary.
// - No interrupt sampling after ccr logic, control load, or reset handling.
// - Trap instruction is always accepted in program execution state.
// - Fixed vector numbers per source: 0, 5, 6, 7, 8-11, 16-21, 24-127.
// - Each vector is four bytes at four times its number.
// - Vector numbers 1-4, 12-15, 22-23 are never assigned.
// - Only advanced-mode vector addresses are generated.
// - Vector fetches always use the advanced 16-Mbyte layout.
// - Trap selects one of four vectors from its two-bit field.
// - Interrupt control mode is 0 after reset, so tracing is off.
// - Mode field 00 is mode 0, 10 is mode 2; others ignored.
module epvu_exception_unit
  import epvu_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Chip pins and watchdog
  input  wire logic              chip_init_pin_n,
  input  wire logic              wdt_overflow,
  // Instruction sequencer
  input  wire logic              boundary,
  input  wire logic              done_return_from_handler,
  input  wire logic              done_ccr_and_instr,
  input  wire logic              done_ccr_or_instr,
  input  wire logic              done_ccr_xor_instr,
  input  wire logic              done_control_load_instr,
  input  wire logic              sleep_direct_transition,
  input  wire logic              software_vector_call,
  input  wire logic [1:0]        software_vector_sel,
  input  wire logic              extended_ctrl_reg_trace,
  // Mode select write
  input  wire logic              mode_wr,
  input  wire logic              irq_ctrl_mode_sel_hi,
  input  wire logic              irq_ctrl_mode_sel_lo,
  // Interrupt controller
  input  wire logic              irq_request,
  input  wire logic [VEC_W-1:0]  irq_vector,
  // Exception start
  output logic                   exc_start_q,
  output logic [4:0]             exc_kind_q,
  output logic [VEC_W-1:0]       exc_vec_q,
  output logic                   irq_ack_q,
  // Vector fetch
  output logic                   fetch_rd_q,
  output logic [ADDR_W-1:0]      fetch_addr_q,
  output logic [2:0]             fetch_bytes_q,
  // Status
  output logic                   cpu_hold_q,
  output logic [1:0]             irq_ctrl_mode_q
);

  // ==========================================================================
  // Vector generator
  epvu_vec_if vec ();

  epvu_vector_gen u_vec_gen (
    .vec (vec.gen)
  );

  // ==========================================================================
  // Interrupt vector legality
  function automatic logic irq_vec_ok(input logic [VEC_W-1:0] v);
    irq_vec_ok = (v == VEC_NMI) ||
                 ((v >= VEC_EXT_FIRST) && (v <= VEC_EXT_LAST)) ||
                 ((v >= VEC_INT_FIRST) && (v <= VEC_INT_LAST));
  endfunction : irq_vec_ok

  // ==========================================================================
  // State and pending flags
  epvu_state_t       state_q;
  epvu_state_t       state_d;
  logic              direct_pend_q;
  logic              direct_pend_d;
  logic              trap_pend_q;
  logic              trap_pend_d;
  logic [1:0]        trap_sel_q;
  logic [1:0]        trap_sel_d;
  logic              after_reset_q;
  logic              after_reset_d;
  logic [1:0]        mode_d;

  logic              take_reset;
  logic              take_trace;
  logic              take_direct;
  logic              take_irq;
  logic              take_trap;
  logic              direct_any;
  logic              trap_any;
  logic              irq_blocked;
  logic [1:0]        trap_sel_now;
  logic [4:0]        kind_d;
  logic [VEC_W-1:0]  vec_d;
  logic              start_d;

  // ==========================================================================
  // Arbitration
  always_comb
  begin
    state_d       = state_q;
    direct_any    = direct_pend_q | sleep_direct_transition;
    trap_any      = trap_pend_q | software_vector_call;
    // Older waiting call is served first
    trap_sel_now  = trap_pend_q ? trap_sel_q : software_vector_sel;
    irq_blocked   = done_ccr_and_instr | done_ccr_or_instr | done_ccr_xor_instr |
                    done_control_load_instr | after_reset_q;
    take_reset    = 1'b0;
    take_trace    = 1'b0;
    take_direct   = 1'b0;
    take_irq      = 1'b0;
    take_trap     = 1'b0;
    unique case (state_q)
      ST_HOLD:
      begin
        if (chip_init_pin_n)
        begin
          state_d    = ST_RUN;
          take_reset = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!chip_init_pin_n)
        begin
          state_d = ST_HOLD;
        end
        else if (wdt_overflow)
        begin
          take_reset = 1'b1;
        end
        else if (boundary)
        begin
          if (extended_ctrl_reg_trace && (irq_ctrl_mode_q == MODE_2) &&
              !done_return_from_handler)
          begin
            take_trace = 1'b1;
          end
          else if (direct_any)
          begin
            take_direct = 1'b1;
          end
          else if (irq_request && !irq_blocked && irq_vec_ok(irq_vector))
          begin
            take_irq = 1'b1;
          end
          else if (trap_any)
          begin
            take_trap = 1'b1;
          end
        end
      end
    endcase

    // Losers stay pending unless a reset is taken or the pin is low; a take consumes the older event, so a new one stays set
    direct_pend_d = take_direct ? (direct_pend_q & sleep_direct_transition)
                                : (direct_pend_q | sleep_direct_transition);
    trap_pend_d   = take_trap ? (trap_pend_q & software_vector_call)
                              : (trap_pend_q | software_vector_call);
    trap_sel_d    = software_vector_call ? software_vector_sel : trap_sel_q;
    if (take_reset || !chip_init_pin_n)
    begin
      direct_pend_d = 1'b0;
      trap_pend_d   = 1'b0;
    end

    after_reset_d = after_reset_q;
    if (take_reset)
    begin
      after_reset_d = 1'b1;
    end
    else if (boundary)
    begin
      after_reset_d = 1'b0;
    end

    mode_d = irq_ctrl_mode_q;
    if (take_reset || !chip_init_pin_n)
    begin
      mode_d = MODE_RESET;
    end
    else if (mode_wr)
    begin
      if ({irq_ctrl_mode_sel_hi, irq_ctrl_mode_sel_lo} == MODE_0)
      begin
        mode_d = MODE_0;
      end
      else if ({irq_ctrl_mode_sel_hi, irq_ctrl_mode_sel_lo} == MODE_2)
      begin
        mode_d = MODE_2;
      end
    end

    start_d = take_reset | take_trace | take_direct | take_irq | take_trap;
    kind_d  = KIND_NONE;
    vec_d   = VEC_RESET;
    if (take_reset)
    begin
      kind_d = KIND_RESET;
      vec_d  = VEC_RESET;
    end
    else if (take_trace)
    begin
      kind_d = KIND_TRACE;
      vec_d  = VEC_TRACE;
    end
    else if (take_direct)
    begin
      kind_d = KIND_DIRECT;
      vec_d  = VEC_DIRECT;
    end
    else if (take_irq)
    begin
      kind_d = KIND_IRQ;
      vec_d  = irq_vector;
    end
    else if (take_trap)
    begin
      kind_d = KIND_TRAP;
      vec_d  = VEC_TRAP_BASE | {5'h00, trap_sel_now};
    end
  end

  assign vec.vec_num = vec_d;

  // ==========================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q         <= ST_HOLD;
      direct_pend_q   <= 1'b0;
      trap_pend_q     <= 1'b0;
      trap_sel_q      <= 2'h0;
      after_reset_q   <= 1'b0;
      irq_ctrl_mode_q <= MODE_RESET;
      exc_start_q     <= 1'b0;
      exc_kind_q      <= KIND_NONE;
      exc_vec_q       <= VEC_RESET;
      irq_ack_q       <= 1'b0;
      fetch_rd_q      <= 1'b0;
      fetch_addr_q    <= {ADDR_W{1'b0}};
      fetch_bytes_q   <= 3'h0;
      cpu_hold_q      <= 1'b1;
    end
    else
    begin
      state_q         <= state_d;
      direct_pend_q   <= direct_pend_d;
      trap_pend_q     <= trap_pend_d;
      trap_sel_q      <= trap_sel_d;
      after_reset_q   <= after_reset_d;
      irq_ctrl_mode_q <= mode_d;
      exc_start_q     <= start_d;
      exc_kind_q      <= kind_d;
      exc_vec_q       <= vec_d;
      irq_ack_q       <= take_irq;
      fetch_rd_q      <= start_d;
      fetch_addr_q    <= start_d ? vec.addr : fetch_addr_q;
      fetch_bytes_q   <= start_d ? FETCH_BYTES : 3'h0;
      cpu_hold_q      <= (state_d == ST_HOLD);
    end
  end

endmodule : epvu_exception_unit

`default_nettype wire

// >>> design/epvu_pkg.sv
package epvu_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned VEC_W  = 7;
  localparam int unsigned ADDR_W = 24;

  // ==========================================================================
  // Vector numbers
  localparam logic [6:0] VEC_RESET      = 7'h00;
  localparam logic [6:0] VEC_TRACE      = 7'h05;
  localparam logic [6:0] VEC_DIRECT     = 7'h06;
  localparam logic [6:0] VEC_NMI        = 7'h07;
  localparam logic [6:0] VEC_TRAP_BASE  = 7'h08;
  localparam logic [6:0] VEC_EXT_FIRST  = 7'h10;
  localparam logic [6:0] VEC_EXT_LAST   = 7'h15;
  localparam logic [6:0] VEC_INT_FIRST  = 7'h18;
  localparam logic [6:0] VEC_INT_LAST   = 7'h7f;

  // ==========================================================================
  // Vector address layout: four bytes per entry
  localparam int unsigned VEC_SHIFT   = 2;
  localparam logic [2:0]  FETCH_BYTES = 3'h4;

  // ==========================================================================
  // Interrupt control mode select encodings
  localparam logic [1:0] MODE_0     = 2'h0;
  localparam logic [1:0] MODE_2     = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // ==========================================================================
  // Exception kind, one-hot
  localparam logic [4:0] KIND_NONE   = 5'h00;
  localparam logic [4:0] KIND_RESET  = 5'h01;
  localparam logic [4:0] KIND_TRACE  = 5'h02;
  localparam logic [4:0] KIND_DIRECT = 5'h04;
  localparam logic [4:0] KIND_IRQ    = 5'h08;
  localparam logic [4:0] KIND_TRAP   = 5'h10;

  // ==========================================================================
  // CPU state
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } epvu_state_t;

endpackage : epvu_pkg

// >>> design/epvu_vec_if.sv
`timescale 1ns/1ns
`default_nettype none

interface epvu_vec_if;
  import epvu_pkg::*;

  logic [VEC_W-1:0]  vec_num;
  logic [ADDR_W-1:0] addr;

  modport gen  (input vec_num, output addr);
  modport user (output vec_num, input addr);
endinterface : epvu_vec_if

`default_nettype wire

// >>> design/epvu_vector_gen.sv
`timescale 1ns/1ns
`default_nettype none

module epvu_vector_gen
  import epvu_pkg::*;
(
  // Vector number in, start address out
  epvu_vec_if.gen vec
);

  // ==========================================================================
  // Address generation
  // Advanced layout only; the upper address bits stay zero
  assign vec.addr = {{(ADDR_W-VEC_W-VEC_SHIFT){1'b0}}, vec.vec_num,
                     {VEC_SHIFT{1'b0}}};

endmodule : epvu_vector_gen

`default_nettype wire

// >>> verification/epvu_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module epvu_assertions
  import epvu_pkg::*;
(
  // Clock, pins, sequencer
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              chip_init_pin_n,
  input wire logic              wdt_overflow,
  input wire logic              boundary,
  input wire logic              done_return_from_handler,
  input wire logic              done_ccr_and_instr,
  input wire logic              done_ccr_or_instr,
  input wire logic              done_ccr_xor_instr,
  input wire logic              done_control_load_instr,
  input wire logic              extended_ctrl_reg_trace,
  input wire logic              mode_wr,
  input wire logic              irq_ctrl_mode_sel_lo,
  // Unit outputs
  input wire logic              exc_start_q,
  input wire logic [4:0]        exc_kind_q,
  input wire logic [VEC_W-1:0]  exc_vec_q,
  input wire logic              irq_ack_q,
  input wire logic              fetch_rd_q,
  input wire logic [ADDR_W-1:0] fetch_addr_q,
  input wire logic [2:0]        fetch_bytes_q,
  input wire logic              cpu_hold_q,
  input wire logic [1:0]        irq_ctrl_mode_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic run = chip_init_pin_n && !wdt_overflow && !cpu_hold_q && boundary;

  // ==========================================================================
  // Properties
  chk_fetch_addr: assert property (exc_start_q |-> fetch_rd_q &&
    fetch_bytes_q == 3'h4 && fetch_addr_q == {15'h0000, exc_vec_q, 2'b00})
    else $error("fetch address or size wrong");
  chk_trap_vec: assert property (exc_kind_q == KIND_TRAP |-> exc_vec_q[6:2] == 5'h02)
    else $error("trap vector out of range");
  chk_hold_pin: assert property (!chip_init_pin_n |=> cpu_hold_q && !exc_start_q)
    else $error("cpu not held with pin low");
  chk_reset_start: assert property (chip_init_pin_n && cpu_hold_q |=>
    exc_start_q && exc_kind_q == KIND_RESET && exc_vec_q == VEC_RESET)
    else $error("reset exception missing");
  chk_wdt_reset: assert property (wdt_overflow && chip_init_pin_n && !cpu_hold_q |=>
    exc_kind_q == KIND_RESET) else $error("watchdog reset missing");
  chk_trace_take: assert property (run && extended_ctrl_reg_trace &&
    irq_ctrl_mode_q == MODE_2 && !done_return_from_handler |=>
    exc_kind_q == KIND_TRACE && exc_vec_q == VEC_TRACE) else $error("trace not taken");
  chk_trace_mode: assert property (exc_kind_q == KIND_TRACE |->
    $past(irq_ctrl_mode_q) == MODE_2) else $error("trace outside mode 2");
  chk_rte_trace: assert property (boundary && done_return_from_handler |=>
    exc_kind_q != KIND_TRACE) else $error("trace after return");
  chk_ccr_irq: assert property (boundary && (done_ccr_and_instr || done_ccr_or_instr ||
    done_ccr_xor_instr || done_control_load_instr) |=> !irq_ack_q)
    else $error("interrupt after ccr or load");
  chk_mode_keep: assert property (mode_wr && irq_ctrl_mode_sel_lo && chip_init_pin_n &&
    !wdt_overflow |=>
    $stable(irq_ctrl_mode_q)) else $error("illegal mode accepted");

  cover property (exc_kind_q == KIND_TRAP);
  cover property (exc_kind_q == KIND_IRQ && irq_ack_q);
  cover property (exc_kind_q == KIND_TRACE);
endmodule : epvu_assertions

bind epvu_exception_unit epvu_assertions u_chk (.*);

`default_nettype wire

// >>> verification/epvu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none

module epvu_seq_model
  import epvu_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Bench control
  input  wire logic             raise,
  input  wire logic [VEC_W-1:0] vec_in,
  // Toward the unit
  input  wire logic             irq_ack_q,
  output logic                  irq_request,
  output logic [VEC_W-1:0]      irq_vector
);
  logic [VEC_W-1:0] vec_q;

  // Request is a level that stands until taken; a new raise beats the old ack
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_request <= 1'b0;
      vec_q       <= 7'h00;
    end
    else if (raise)
    begin
      irq_request <= 1'b1;
      vec_q       <= vec_in;
    end
    else if (irq_ack_q)
    begin
      irq_request <= 1'b0;
    end
  end
  // Released vector lines show the inverted last vector
  assign irq_vector = irq_request ? vec_q : ~vec_q;
endmodule : epvu_seq_model

`default_nettype wire

// >>> verification/exception_priority_vector_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none

module exception_priority_vector_unit_bench
  import epvu_pkg::*;
;
  typedef struct packed {
    logic m2, tr, sl, tp; logic [1:0] sel; logic rq; logic [6:0] iv; logic [4:0] k;
    logic [6:0] v;
  } epvu_row_t;
  logic clk = 0, reset = 1, chip_init_pin_n = 1, wdt_overflow = 0, boundary = 0, raise = 0;
  logic done_return_from_handler = 0, done_ccr_and_instr = 0, done_ccr_or_instr = 0;
  logic done_ccr_xor_instr = 0, done_control_load_instr = 0, sleep_direct_transition = 0;
  logic software_vector_call = 0, extended_ctrl_reg_trace = 0, mode_wr = 0;
  logic irq_ctrl_mode_sel_hi = 0, irq_ctrl_mode_sel_lo = 0;
  logic irq_request, exc_start_q, irq_ack_q, fetch_rd_q, cpu_hold_q;
  logic [1:0] software_vector_sel = 2'h0, irq_ctrl_mode_q;
  logic [VEC_W-1:0] vec_in = 7'h00, irq_vector, exc_vec_q;
  logic [4:0] exc_kind_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic [2:0] fetch_bytes_q;
  int n_errors = 0, check_count = 0, cycles = 0;
  epvu_row_t r;
  epvu_row_t rows [16] = '{
    '{0,0,0,1,0,0,0,KIND_TRAP,8}, '{0,0,0,1,1,0,0,KIND_TRAP,9},
    '{0,0,0,1,2,0,0,KIND_TRAP,10}, '{0,0,0,1,3,0,0,KIND_TRAP,11},
    '{0,0,0,0,0,1,7,KIND_IRQ,7}, '{0,0,0,0,0,1,16,KIND_IRQ,16},
    '{0,0,0,0,0,1,21,KIND_IRQ,21}, '{0,0,0,0,0,1,127,KIND_IRQ,127},
    '{0,0,1,0,0,0,0,KIND_DIRECT,6},
    '{0,1,0,0,0,0,0,KIND_NONE,0},
    '{1,1,0,0,0,0,0,KIND_TRACE,5},
    '{1,1,1,1,2,1,24,KIND_TRACE,5},
    '{0,0,0,0,0,0,0,KIND_DIRECT,6}, '{0,0,0,0,0,0,0,KIND_IRQ,24},
    '{0,0,0,0,0,0,0,KIND_TRAP,10},
    '{0,0,0,0,0,1,22,KIND_NONE,0}
  };

  epvu_exception_unit uut (.*);
  epvu_seq_model u_model (.*);

  always #5 clk = ~clk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse_boundary;
    boundary = 1;
    @(negedge clk);
    {boundary, done_return_from_handler, done_ccr_and_instr, done_ccr_or_instr,
     done_ccr_xor_instr, done_control_load_instr, sleep_direct_transition,
     software_vector_call, raise, mode_wr} = '0;
  endtask : pulse_boundary

  task automatic wait_reset_exc;
    for (int k = 0; k < 8 && exc_start_q !== 1'b1; k++) @(negedge clk);
    chk(exc_kind_q, KIND_RESET);
    chk(fetch_addr_q, 24'h00_0000);
    chk(irq_ctrl_mode_q, MODE_0);
    $display("reset exception test done");
  endtask : wait_reset_exc

  task automatic do_reset;
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    wait_reset_exc;
  endtask : do_reset

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      close_out;
    end
  end

  // ==========================================================================
  // Sequence
  initial
  begin
    @(negedge clk);
    do_reset;
    for (int i = 0; i < 16; i++)
    begin
      r = rows[i];
      {irq_ctrl_mode_sel_hi, mode_wr, extended_ctrl_reg_trace, raise, vec_in} = {r.m2, 1'b1, r.tr, r.rq, r.iv};
      @(negedge clk);
      {mode_wr, raise, sleep_direct_transition, software_vector_call} = {2'b0, r.sl, r.tp};
      software_vector_sel = r.sel;
      pulse_boundary;
      chk(exc_kind_q, r.k);
      chk(exc_vec_q, r.v);
      $display("row %0d done", i);
    end
    do_reset;
    {raise, vec_in} = {1'b1, 7'h10};
    @(negedge clk);
    pulse_boundary;
    chk(irq_ack_q, 1'b0);
    for (int q = 0; q < 4; q++)
    begin
      {done_ccr_and_instr, done_ccr_or_instr, done_ccr_xor_instr, done_control_load_instr} = 4'h1 << q;
      pulse_boundary;
      chk(irq_ack_q, 1'b0);
    end
    pulse_boundary;
    chk(exc_kind_q, KIND_IRQ);
    $display("interrupt blocking test done");
    {mode_wr, irq_ctrl_mode_sel_hi, extended_ctrl_reg_trace} = 3'h7;
    @(negedge clk);
    done_return_from_handler = 1;
    pulse_boundary;
    chk(exc_kind_q, KIND_NONE);
    {mode_wr, irq_ctrl_mode_sel_hi, irq_ctrl_mode_sel_lo, extended_ctrl_reg_trace} = 4'hb;
    @(negedge clk);
    {mode_wr, irq_ctrl_mode_sel_lo} = 2'h0;
    @(negedge clk);
    chk(irq_ctrl_mode_q, MODE_2);
    $display("return and mode test done");
    chip_init_pin_n = 0;
    @(negedge clk);
    chk(cpu_hold_q, 1'b1);
    chip_init_pin_n = 1;
    wait_reset_exc;
    wdt_overflow = 1;
    @(negedge clk);
    wdt_overflow = 0;
    chk(exc_kind_q, KIND_RESET);
    $display("pin and watchdog test done");
    close_out;
  end
endmodule : exception_priority_vector_unit_bench

`default_nettype wire
